//--- logic/timer_bank.sv
// Three gated 16-bit timer/counters behind a byte-wide register port
//
// Contract
// (R01) 16-bit up counter, byte-wide access, writes load immediately.
// (R02) On clear: off; on without gate-enable: counts; both: gate qualifies.
// (R03) Source 11 low-freq osc, 10 external pin, 01 system, 00 instruction clock.
// (R04) System clock source advances four counts per instruction cycle.
// (R05) External source counts rising edges, synchronized or asynchronous.
// (R06) Counter mode needs a falling edge before first counted rising edge.
// (R07) Prescaler divides selected clock by 1, 2, 4 or 8.
// (R08) Prescaler hidden from software, cleared by any count byte write.
// (R09) Oscillator enable starts the crystal oscillator, running through Sleep.
// (R10) Software waits for crystal start, e.g. preset FC00h, await overflow.
// (R11) Active-low sync bit set bypasses synchronization of the external clock; here edges always pass the synchronizer, the bit only allows Sleep counting.
// (R12) Async external counting continues in Sleep; overflow wakes the processor.
// (R13) Mode switches may drop or add one increment; not prevented.
// (R14) Three identical timer instances, each with own counter and controls.
// (R15) Full resolution with system clock needs an asynchronous gate; here the gate level always passes the pin synchronizer.
// (R16) Rollover FFFFh to 0000h sets the overflow flag.
// (R17) Gated counting only while gate level equals gate polarity.
// (R18) Synchronized external clock passes synchronizer; edges taken after it.
// (R19) Reset clears count, prescaler, overflow flag and all controls.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module timer_bank (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [timer_bank_pkg::ADDR_W-1:0] addr,
  input wire logic [timer_bank_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [timer_bank_pkg::DATA_W-1:0] rd_data,
  // Processor state
  input wire logic sleep_mode,
  // Timer pins and gate inputs, one bit per timer
  input wire logic [timer_bank_pkg::NUM_TIMERS-1:0] ext_count_input,
  input wire logic [timer_bank_pkg::NUM_TIMERS-1:0] crystal_in_pin,
  input wire logic [timer_bank_pkg::NUM_TIMERS-1:0] gate_level,
  output logic [timer_bank_pkg::NUM_TIMERS-1:0] crystal_out_pin,
  output logic [timer_bank_pkg::NUM_TIMERS-1:0] crystal_osc_en,
  // Interrupt and wake
  output logic irq,
  output logic wake_req
);

  localparam int N = timer_bank_pkg::NUM_TIMERS;
  localparam int DW = timer_bank_pkg::DATA_W;
  localparam int CW = timer_bank_pkg::COUNT_W;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Hit on register off of timer idx
  function automatic logic reg_hit(input logic [timer_bank_pkg::ADDR_W-1:0] a,
                                   input int idx,
                                   input logic [timer_bank_pkg::ADDR_W-1:0] off);
    logic [timer_bank_pkg::ADDR_W-1:0] base;
    base = timer_bank_pkg::ADDR_W'(idx * int'(timer_bank_pkg::REG_STRIDE));
    return a == (base + off);
  endfunction

  // ----------------------------------------------------------------
  // Rate dividers
  // ----------------------------------------------------------------
  logic [1:0] instr_cnt_r, instr_cnt_nxt;
  logic [timer_bank_pkg::LF_CNT_W-1:0] lf_cnt_r, lf_cnt_nxt;
  logic instr_tick, lf_tick;

  // Instruction clock and low-frequency oscillator as enable pulses
  always_comb begin
    instr_tick = (instr_cnt_r == timer_bank_pkg::INSTR_LAST);
    lf_tick = (lf_cnt_r == timer_bank_pkg::LF_LAST);
    instr_cnt_nxt = instr_tick ? 2'h0 : instr_cnt_r + 2'h1;
    lf_cnt_nxt = lf_tick ? '0 : lf_cnt_r + 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      instr_cnt_r <= 2'h0;
      lf_cnt_r <= '0;
    end else begin
      instr_cnt_r <= instr_cnt_nxt;
      lf_cnt_r <= lf_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronizers
  // ----------------------------------------------------------------
  logic [N-1:0] pin_lvl, pin_rise, pin_fall;
  logic [N-1:0] xtal_lvl, xtal_rise, xtal_fall;
  logic [N-1:0] gate_sync;

  genvar gs;
  generate
    for (gs = 0; gs < N; gs++) begin : g_sync
      // (R18) external pin synchronizer
      pin_sync u_pin (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin_in(ext_count_input[gs]),
        .level(pin_lvl[gs]),
        .rise(pin_rise[gs]),
        .fall(pin_fall[gs])
      );
      pin_sync u_xtal (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin_in(crystal_in_pin[gs]),
        .level(xtal_lvl[gs]),
        .rise(xtal_rise[gs]),
        .fall(xtal_fall[gs])
      );
      pin_sync u_gate (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin_in(gate_level[gs]),
        .level(gate_sync[gs]),
        .rise(),
        .fall()
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Timer instances
  // ----------------------------------------------------------------
  logic [N-1:0] ovf_evt;
  logic [N-1:0] osc_en_bits;
  logic [DW-1:0] inst_rd [N];

  genvar gi;
  generate
    // (R14) three identical timers
    for (gi = 0; gi < N; gi++) begin : g_tmr
      logic [CW-1:0] cnt_r, cnt_nxt;
      logic [timer_bank_pkg::PS_W-1:0] ps_r, ps_nxt;
      logic armed_r, armed_nxt;
      logic [DW-1:0] ctrl_r, ctrl_nxt;
      logic [DW-1:0] gate_r, gate_nxt;
      logic xout_r, xout_nxt;
      logic wr_lo, wr_hi, wr_cnt, on, sync_n, osc_en, gate_en, gate_pol, run;
      logic ext_rise, ext_fall, src_tick, pre_tick;
      logic [timer_bank_pkg::PS_W-1:0] ps_mask;
      timer_bank_pkg::clk_src_type src;

      always_comb begin
        wr_lo = wr_en && reg_hit(addr, gi, timer_bank_pkg::OFF_COUNT_LOW);
        wr_hi = wr_en && reg_hit(addr, gi, timer_bank_pkg::OFF_COUNT_HIGH);
        wr_cnt = wr_lo || wr_hi;
        on = ctrl_r[timer_bank_pkg::CTRL_ON_BIT];
        sync_n = ctrl_r[timer_bank_pkg::CTRL_SYNC_N_BIT];
        osc_en = ctrl_r[timer_bank_pkg::CTRL_OSC_EN_BIT];
        gate_en = gate_r[timer_bank_pkg::GATE_EN_BIT];
        gate_pol = gate_r[timer_bank_pkg::GATE_POL_BIT];
        src = timer_bank_pkg::clk_src_type'(ctrl_r[timer_bank_pkg::CTRL_CS_LSB +: 2]);
        // (R07) prescale mask for 1, 2, 4, 8
        ps_mask = timer_bank_pkg::PS_W'((4'h1 << ctrl_r[timer_bank_pkg::CTRL_PS_LSB +: 2])
                                        - 4'h1);
        // (R09) crystal path when oscillator enabled
        ext_rise = osc_en ? xtal_rise[gi] : pin_rise[gi];
        ext_fall = osc_en ? xtal_fall[gi] : pin_fall[gi];
        // (R02) enable table; (R17) gate level against polarity
        run = on && (!gate_en || (gate_sync[gi] == gate_pol));
        // (R03) source select
        case (src)
          timer_bank_pkg::SRC_INSTR: src_tick = instr_tick && !sleep_mode;
          // (R04) every system cycle, four per instruction
          timer_bank_pkg::SRC_SYS: src_tick = !sleep_mode;
          timer_bank_pkg::SRC_LF: src_tick = lf_tick && !sleep_mode;
          // (R13) sync/async switch left unguarded
          // (R05) external rising edge; (R11) (R12) async keeps running in Sleep
          timer_bank_pkg::SRC_EXT: src_tick = ext_rise && armed_r && (sync_n || !sleep_mode);
          default: src_tick = 1'b0;
        endcase
        pre_tick = run && src_tick && ((ps_r & ps_mask) == ps_mask);
        // (R08) write to a count byte clears prescaler
        if (wr_cnt) begin
          ps_nxt = timer_bank_pkg::PS_RST;
        end else if (pre_tick) begin
          ps_nxt = timer_bank_pkg::PS_RST;
        end else if (run && src_tick) begin
          ps_nxt = ps_r + 3'h1;
        end else begin
          ps_nxt = ps_r;
        end
        // (R01) byte writes load at once and beat an increment
        if (wr_lo) begin
          cnt_nxt = {cnt_r[CW-1:DW], wr_data};
        end else if (wr_hi) begin
          cnt_nxt = {wr_data, cnt_r[DW-1:0]};
        end else if (pre_tick) begin
          cnt_nxt = cnt_r + 16'h0001;
        end else begin
          cnt_nxt = cnt_r;
        end
        // (R16) rollover event
        ovf_evt[gi] = pre_tick && !wr_cnt && (cnt_r == timer_bank_pkg::COUNT_MAX);
        // (R06) disarm on write or off, arm on falling edge
        if (wr_cnt || !on) begin
          armed_nxt = 1'b0;
        end else if (ext_fall) begin
          armed_nxt = 1'b1;
        end else begin
          armed_nxt = armed_r;
        end
        ctrl_nxt = ctrl_r;
        if (wr_en && reg_hit(addr, gi, timer_bank_pkg::OFF_CTRL)) begin
          ctrl_nxt = wr_data & timer_bank_pkg::CTRL_WR_MASK;
        end
        gate_nxt = gate_r;
        if (wr_en && reg_hit(addr, gi, timer_bank_pkg::OFF_GATE)) begin
          gate_nxt = wr_data & timer_bank_pkg::GATE_WR_MASK;
        end
        // (R09) oscillator amplifier inverts input while enabled
        xout_nxt = osc_en && !xtal_lvl[gi];
        // Register read view for this timer
        if (reg_hit(addr, gi, timer_bank_pkg::OFF_COUNT_LOW)) begin
          inst_rd[gi] = cnt_r[DW-1:0];
        end else if (reg_hit(addr, gi, timer_bank_pkg::OFF_COUNT_HIGH)) begin
          inst_rd[gi] = cnt_r[CW-1:DW];
        end else if (reg_hit(addr, gi, timer_bank_pkg::OFF_CTRL)) begin
          inst_rd[gi] = ctrl_r;
        end else if (reg_hit(addr, gi, timer_bank_pkg::OFF_GATE)) begin
          inst_rd[gi] = gate_r | (DW'(gate_sync[gi]) << timer_bank_pkg::GATE_VAL_BIT);
        end else begin
          inst_rd[gi] = '0;
        end
      end

      // (R19) everything clears, timer off
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          cnt_r <= timer_bank_pkg::COUNT_RST;
          ps_r <= timer_bank_pkg::PS_RST;
          armed_r <= 1'b0;
          ctrl_r <= timer_bank_pkg::CTRL_RST;
          gate_r <= timer_bank_pkg::GATE_RST;
          xout_r <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          ps_r <= ps_nxt;
          armed_r <= armed_nxt;
          ctrl_r <= ctrl_nxt;
          gate_r <= gate_nxt;
          xout_r <= xout_nxt;
        end
      end

      assign osc_en_bits[gi] = ctrl_r[timer_bank_pkg::CTRL_OSC_EN_BIT];
      assign crystal_out_pin[gi] = xout_r;
    end
  endgenerate

  assign crystal_osc_en = osc_en_bits;

  // ----------------------------------------------------------------
  // Interrupt status, mask and read port
  // ----------------------------------------------------------------
  logic [N-1:0] sts_r, sts_nxt, mask_r, mask_nxt;
  logic irq_r, irq_nxt, wake_r, wake_nxt;
  logic [DW-1:0] rd_data_r, rd_data_nxt;

  // Set beats write-one-clear so a same-cycle overflow is kept
  always_comb begin
    sts_nxt = sts_r;
    if (wr_en && (addr == timer_bank_pkg::OFF_IRQ_STATUS)) begin
      sts_nxt = sts_r & ~wr_data[N-1:0];
    end
    // (R16) overflow sets the flag
    sts_nxt = sts_nxt | ovf_evt;
    mask_nxt = mask_r;
    if (wr_en && (addr == timer_bank_pkg::OFF_IRQ_MASK)) begin
      mask_nxt = wr_data[N-1:0];
    end
    irq_nxt = |(sts_r & mask_r);
    // (R12) unmasked overflow during Sleep wakes the processor
    wake_nxt = sleep_mode && irq_nxt;
    rd_data_nxt = '0;
    if (rd_en) begin
      if (addr == timer_bank_pkg::OFF_IRQ_STATUS) begin
        rd_data_nxt = DW'(sts_r);
      end else if (addr == timer_bank_pkg::OFF_IRQ_MASK) begin
        rd_data_nxt = DW'(mask_r);
      end else begin
        for (int k = 0; k < N; k++) begin
          rd_data_nxt = rd_data_nxt | inst_rd[k];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sts_r <= timer_bank_pkg::IRQ_RST;
      mask_r <= timer_bank_pkg::IRQ_RST;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      sts_r <= sts_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign irq = irq_r;
  assign wake_req = wake_r;
  assign rd_data = rd_data_r;

endmodule

//--- logic/timer_bank_pkg.sv
// Shared constants and types for the gated 16-bit timer bank
package timer_bank_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_TIMERS = 3;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 16;
  localparam int PS_W = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned LF_OSC_HZ = 31_000;
  // Longest period rounds down, never below one cycle
  localparam int unsigned LF_DIV_CYCLES =
    (SYS_CLK_HZ / LF_OSC_HZ) < 1 ? 1 : (SYS_CLK_HZ / LF_OSC_HZ);
  localparam int unsigned INSTR_DIV_CYCLES = 4;
  localparam int LF_CNT_W = 12;
  localparam logic [LF_CNT_W-1:0] LF_LAST = LF_CNT_W'(LF_DIV_CYCLES - 1);
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV_CYCLES - 1);

  // ----------------------------------------------------------------
  // Register offsets (each timer takes a block of four)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_STRIDE = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LOW = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_GATE = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'hC;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'hD;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_SYNC_N_BIT = 2;
  localparam int CTRL_OSC_EN_BIT = 3;
  localparam int CTRL_PS_LSB = 4;
  localparam int CTRL_CS_LSB = 6;
  localparam int GATE_VAL_BIT = 2;
  localparam int GATE_POL_BIT = 6;
  localparam int GATE_EN_BIT = 7;
  localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'hFD;
  localparam logic [DATA_W-1:0] GATE_WR_MASK = 8'hC0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] GATE_RST = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [NUM_TIMERS-1:0] IRQ_RST = 3'h0;
  localparam logic [PS_W-1:0] PS_RST = 3'h0;

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_INSTR = 2'b00,
    SRC_SYS = 2'b01,
    SRC_EXT = 2'b10,
    SRC_LF = 2'b11
  } clk_src_type;

endpackage

//--- logic/pin_sync.sv
// Three-stage pin synchronizer with agreed level and edge pulses
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Asynchronous pin
  input wire logic pin_in,
  // Synchronized results
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_r, s2_r, s3_r;
  logic level_r, level_nxt;
  logic rise_r, rise_nxt;
  logic fall_r, fall_nxt;

  // Level only moves once stages two and three agree
  always_comb begin
    level_nxt = (s2_r == s3_r) ? s3_r : level_r;
    rise_nxt = level_nxt & ~level_r;
    fall_nxt = ~level_nxt & level_r;
  end

  // First stage feeds only the second, to contain metastability
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign level = level_r;
  assign rise = rise_r;
  assign fall = fall_r;

endmodule

//--- testbench/timer_bank_monitor.sv
// Port checker for the timer bank, bound to its top module
`timescale 1ns/1ps
module timer_bank_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [timer_bank_pkg::ADDR_W-1:0] addr,
  input wire logic [timer_bank_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [timer_bank_pkg::DATA_W-1:0] rd_data,
  // Pins and events
  input wire logic sleep_mode,
  input wire logic [timer_bank_pkg::NUM_TIMERS-1:0] ext_count_input,
  input wire logic [timer_bank_pkg::NUM_TIMERS-1:0] crystal_in_pin,
  input wire logic [timer_bank_pkg::NUM_TIMERS-1:0] gate_level,
  input wire logic [timer_bank_pkg::NUM_TIMERS-1:0] crystal_out_pin,
  input wire logic [timer_bank_pkg::NUM_TIMERS-1:0] crystal_osc_en,
  input wire logic irq,
  input wire logic wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // --------------------------------------------
  // Sequences and properties
  // --------------------------------------------
  // Control write of the first timer
  sequence s_ctrl_wr;
    wr_en && addr == timer_bank_pkg::OFF_CTRL;
  endsequence
  // Mask write that blocks every source
  sequence s_mask_clear;
    wr_en && addr == timer_bank_pkg::OFF_IRQ_MASK && wr_data[2:0] == 3'h0;
  endsequence
  property p_rd_idle;
    !rd_en |=> rd_data == 8'h00;
  endproperty
  property p_unmapped;
    rd_en && addr == 4'hE |=> rd_data == 8'h00;
  endproperty
  // Own disable: this one must hold while reset is low
  property p_reset_quiet;
    disable iff (1'b0) !rst_b |=> rd_data == 8'h00 && !irq && !wake_req
      && crystal_osc_en == 3'h0 && crystal_out_pin == 3'h0;
  endproperty
  property p_mask_off;
    s_mask_clear |-> ##2 !irq;
  endproperty
  property p_wake_on;
    (irq && sleep_mode) [*3] |-> wake_req;
  endproperty
  property p_wake_off;
    (!sleep_mode) [*3] |-> !wake_req;
  endproperty
  property p_osc_follow;
    s_ctrl_wr |-> ##2 crystal_osc_en[0] == $past(wr_data[3], 2);
  endproperty
  // Synchronizer latency is covered by the six quiet cycles
  property p_osc_out;
    (crystal_osc_en[0] && !crystal_in_pin[0]) [*6] |-> crystal_out_pin[0];
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("hidden place readable");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs after reset");
  a_mask_off: assert property (p_mask_off) else $error("masked irq seen");
  a_wake_on: assert property (p_wake_on) else $error("no wake in sleep");
  a_wake_off: assert property (p_wake_off) else $error("wake while awake");
  a_osc_follow: assert property (p_osc_follow) else $error("osc enable wrong");
  a_osc_out: assert property (p_osc_out) else $error("osc drive missing");
endmodule

bind timer_bank timer_bank_monitor u_timer_bank_monitor (
  .core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .sleep_mode(sleep_mode),
  .ext_count_input(ext_count_input), .crystal_in_pin(crystal_in_pin),
  .gate_level(gate_level), .crystal_out_pin(crystal_out_pin),
  .crystal_osc_en(crystal_osc_en), .irq(irq), .wake_req(wake_req)
);

//--- testbench/count_pin_source.sv
// Model of the external count pin and the crystal feeding the timers
`timescale 1ns/1ps
module count_pin_source (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Burst request
  input wire logic start,
  input wire logic [11:0] n_pulses,
  input wire logic [3:0] half_cyc,
  input wire logic use_xtal,
  // Pins
  output logic ext_pin,
  output logic xtal_pin,
  output logic busy
);
  logic lvl_r;
  logic [11:0] left_r;
  logic [3:0] tick_r;

  // rising edges, unarmed first
  // Each pulse is low then high, so a burst opens with a rise and no fall
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lvl_r <= 1'b0;
      left_r <= 12'h000;
      tick_r <= 4'h0;
    end else if (start && left_r == 12'h000) begin
      left_r <= n_pulses;
      tick_r <= 4'h0;
    end else if (left_r != 12'h000) begin
      if (tick_r == half_cyc - 4'h1) begin
        tick_r <= 4'h0;
        lvl_r <= !lvl_r;
        if (lvl_r) begin
          left_r <= left_r - 12'h001;
        end
      end else begin
        tick_r <= tick_r + 4'h1;
      end
    end
  end

  // Pin rests low between bursts
  assign ext_pin = lvl_r && !use_xtal;
  assign xtal_pin = lvl_r && use_xtal;
  assign busy = left_r != 12'h000;
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the three-timer bank
`timescale 1ns/1ps
module tb_top;
  // --------------------------------------------
  // Signals and instances
  // --------------------------------------------
  logic core_clk = 1'b0;
  logic rst_b;
  logic [timer_bank_pkg::ADDR_W-1:0] addr;
  logic [timer_bank_pkg::DATA_W-1:0] wr_data, rd_data, d, e;
  logic wr_en, rd_en, sleep_mode, irq, wake_req;
  logic [2:0] gate_level, crystal_out_pin, crystal_osc_en;
  logic p_start, p_xtal, p_ext, p_xin, p_busy;
  logic [11:0] p_n;
  logic [3:0] p_half;
  int err_count, n_checks, t, seed;
  int cyc = 0;

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  timer_bank u_timer_bank (.core_clk(core_clk), .rst_b(rst_b), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .sleep_mode(sleep_mode), .ext_count_input({3{p_ext}}), .crystal_in_pin({3{p_xin}}),
    .gate_level(gate_level), .crystal_out_pin(crystal_out_pin),
    .crystal_osc_en(crystal_osc_en), .irq(irq), .wake_req(wake_req));
  count_pin_source u_count_pin_source (.core_clk(core_clk), .rst_b(rst_b), .start(p_start),
    .n_pulses(p_n), .half_cyc(p_half), .use_xtal(p_xtal), .ext_pin(p_ext),
    .xtal_pin(p_xin), .busy(p_busy));

  // Hang guard, about three and a half times the expected run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // --------------------------------------------
  // Bus, pin and check tasks
  // --------------------------------------------
  function automatic logic [3:0] base(input int i, input int o);
    return 4'(4 * i + o);
  endfunction
  // Ends mid-cycle so pin checks see settled outputs
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic x, input logic g);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", nm, x, g);
    end
  endtask
  // Low byte read twice exactly k cycles apart
  task automatic rate(input int i, input int k, input logic [7:0] x);
    logic [7:0] d0;
    logic [7:0] d1;
    rd(base(i, 0), d0);
    repeat (k - 1) @(posedge core_clk);
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d1 = rd_data;
    chk("count delta", x, d1 - d0);
  endtask
  // Burst from the pin model, then let the synchronizer drain
  task automatic pulses(input int n, input logic [3:0] h, input logic x);
    @(posedge core_clk);
    p_n <= 12'(n);
    p_half <= h;
    p_xtal <= x;
    p_start <= 1'b1;
    @(posedge core_clk);
    p_start <= 1'b0;
    #1;
    while (p_busy !== 1'b0) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // --------------------------------------------
  // Main sequence
  // --------------------------------------------
  initial begin
    rst_b = 1'b0;
    addr = 4'h0;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    sleep_mode = 1'b0;
    gate_level = 3'h0;
    p_start = 1'b0;
    p_n = 12'h000;
    p_half = 4'h3;
    p_xtal = 1'b0;
    err_count = 0;
    n_checks = 0;
    seed = $urandom(55500);
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      for (int o = 0; o < 4; o++) begin
        rd(base(i, o), d);
        chk("reset reg", 8'h00, d);
      end
      e = 8'($urandom);
      wr(base(i, 0), e);
      wr(base(i, 1), ~e);
      wr(base(i, 2), e & 8'hFE);
      rd(base(i, 2), d);
      chk("ctrl", e & timer_bank_pkg::CTRL_WR_MASK & 8'hFE, d);
      rd(base(i, 0), d);
      chk("count low", e, d);
      rd(base(i, 1), d);
      chk("count high", ~e, d);
      wr(base(i, 2), 8'h00);
    end
    wr(4'hF, 8'hFF);
    rd(4'hF, d);
    chk("unmapped", 8'h00, d);
    rd(4'hE, d);
    chk("hidden", 8'h00, d);
    // Every internal source and prescale on one random timer
    t = $urandom_range(2);
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr(base(t, 2), {2'(s), 2'(p), 4'h1});
        rate(t, 160, 8'(160 / ((s == 0 ? 4 : 1) << p)));
      end
    end
    wr(base(t, 2), 8'hC1);
    rate(t, 2 * int'(timer_bank_pkg::LF_DIV_CYCLES), 8'h02);
    wr(base(t, 2), 8'h40);
    rate(t, 160, 8'h00);
    e[0] = 1'($urandom);
    @(posedge core_clk);
    gate_level[t] <= e[0];
    wr(base(t, 3), {1'b1, e[0], 6'h00});
    rate(t, 160, 8'h00);
    wr(base(t, 2), 8'h41);
    rate(t, 160, 8'hA0);
    @(posedge core_clk);
    gate_level[t] <= !e[0];
    repeat (6) @(posedge core_clk);
    rate(t, 160, 8'h00);
    wr(base(t, 3), 8'h00);
    wr(base(t, 2), 8'h00);
    // Rollover, mask, wake and clear
    t = $urandom_range(2);
    wr(base(t, 2), 8'h00);
    wr(timer_bank_pkg::OFF_IRQ_MASK, 8'(1 << t));
    wr(base(t, 0), 8'hFF);
    wr(base(t, 1), 8'hFF);
    wr(timer_bank_pkg::OFF_IRQ_STATUS, 8'h07);
    wr(base(t, 2), 8'h41);
    wr(base(t, 2), 8'h00);
    chk_pin("irq", 1'b1, irq);
    rd(timer_bank_pkg::OFF_IRQ_STATUS, d);
    chk("flag", 8'(1 << t), d);
    wr(timer_bank_pkg::OFF_IRQ_MASK, 8'h00);
    // Registered irq trails the write by one cycle
    @(negedge core_clk);
    chk_pin("masked irq", 1'b0, irq);
    wr(timer_bank_pkg::OFF_IRQ_MASK, 8'(1 << t));
    @(posedge core_clk);
    sleep_mode <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk_pin("wake", 1'b1, wake_req);
    @(posedge core_clk);
    sleep_mode <= 1'b0;
    wr(timer_bank_pkg::OFF_IRQ_STATUS, 8'(1 << t));
    @(negedge core_clk);
    chk_pin("cleared irq", 1'b0, irq);
    // External pin: arming, sync freeze, async sleep counting
    wr(base(t, 2), 8'h81);
    wr(base(t, 0), 8'h00);
    wr(base(t, 1), 8'h00);
    pulses(5, 4'h6, 1'b0);
    pulses(3, 4'h3, 1'b0);
    rd(base(t, 0), d);
    chk("ext count", 8'h07, d);
    @(posedge core_clk);
    sleep_mode <= 1'b1;
    pulses(4, 4'h3, 1'b0);
    sleep_mode <= 1'b0;
    rd(base(t, 0), d);
    chk("sync sleep", 8'h07, d);
    wr(base(t, 2), 8'h85);
    wr(base(t, 0), 8'h00);
    @(posedge core_clk);
    sleep_mode <= 1'b1;
    pulses(6, 4'h3, 1'b0);
    sleep_mode <= 1'b0;
    rd(base(t, 0), d);
    chk("async sleep", 8'h05, d);
    // Crystal start-up check through a preset count
    wr(base(0, 2), 8'h89);
    chk_pin("osc on", 1'b1, crystal_osc_en[0]);
    wr(timer_bank_pkg::OFF_IRQ_STATUS, 8'h07);
    wr(base(0, 0), 8'h00);
    wr(base(0, 1), 8'hFC);
    pulses(1024, 4'h3, 1'b1);
    rd(timer_bank_pkg::OFF_IRQ_STATUS, d);
    chk("flag early", 8'h00, d);
    pulses(1, 4'h3, 1'b1);
    rd(timer_bank_pkg::OFF_IRQ_STATUS, d);
    chk("flag late", 8'h01, d);
    wr(base(0, 2), 8'h00);
    chk_pin("osc off", 1'b0, crystal_osc_en[0]);
    tally_and_finish();
  end
endmodule
